/* File: hdl/flash_path_pkg.sv */
// shared constants and types for the flash path select block
package flash_path_pkg;

  // address map of the flash controllers and the select register
  localparam logic [31:0] XIP_MEM_BASE = 32'h0000_0000;
  localparam logic [31:0] XIP_MEM_SIZE = 32'h0100_0000;
  localparam logic [31:0] XIP_CFG_BASE = 32'h0400_0000;
  localparam logic [31:0] PATH_SEL_BASE = 32'h4001_0000;
  localparam logic [31:0] NORMAL_BASE = 32'h4002_0000;
  localparam logic [31:0] SD_BASE = 32'h4003_0000;
  localparam logic [31:0] PERIPH_SIZE = 32'h0001_0000;

  // select register fields
  localparam int SEL_BIT = 0;
  localparam int APPLIED_BIT = 1;
  localparam int DETECT_BIT = 2;
  localparam logic SEL_RESET = 1'b0;
  localparam logic SEL_XIP = 1'b0;
  localparam logic SEL_NORMAL = 1'b1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // terminal link framing, carried through unchanged
  localparam int TERM_BAUD = 115200;
  localparam int TERM_DATA_BITS = 8;
  localparam int TERM_STOP_BITS = 1;
  localparam logic UART_IDLE = 1'b1;

  // flash data lanes
  localparam int FLASH_LANES = 4;

  // target of a processor bus access
  typedef enum logic [2:0] {
    REGION_NONE,
    REGION_XIP_MEM,
    REGION_XIP_CFG,
    REGION_PATH_SEL,
    REGION_NORMAL,
    REGION_SD
  } region_type;

  // processor bus request
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_type;

  // processor bus answer
  typedef struct packed {
    logic ready;
    logic error;
    logic [31:0] rdata;
  } bus_rsp_type;

  // drive of the flash pins by one controller
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [FLASH_LANES-1:0] io_out;
    logic [FLASH_LANES-1:0] io_oe;
  } flash_drive_type;

  localparam flash_drive_type FLASH_IDLE = '{
    sclk: 1'b0,
    cs_n: 1'b1,
    io_out: 4'h0,
    io_oe: 4'h0
  };

endpackage

/* File: hdl/level_sync.sv */
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage is read only by the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      meta_q <= data_i;
      sync_q <= meta_q;
    end
  end

  assign data_o = sync_q;

endmodule // level_sync

/* File: hdl/flash_path_mux.sv */
// flash path select, address map and terminal routing
//
// Function
// RQ1 - execute-in-place memory window at 0x0000000 fetches code from flash.
// RQ2 - execute-in-place configuration port decoded at 0x4000000.
// RQ3 - normal-mode flash controller decoded at 0x40020000.
// RQ4 - bit 0 of the register at 0x40010000 picks the flash owner.
// RQ5 - select 0 gives pins to execute-in-place path, read only.
// RQ6 - select bit resets to 0, the execute-in-place path.
// RQ7 - select 1 gives pins to the normal-mode controller.
// RQ8 - code running from flash must keep the select bit low.
// RQ9 - SD card SPI controller decoded at 0x40030000.
// RQ10 - a new flash image only runs after a processor reset.
// RQ11 - jumper fitted sends terminal to adaptor port, else base port.
// RQ12 - both terminal links run 115200 baud, 8 data, 1 stop, no parity.
// RQ13 - adaptor reset resets system and peripherals, never debug logic.
// RQ14 - clock, select and four data lines switch together on registered bit.
`timescale 1ns/100ps
module flash_path_mux (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic LINK_CLK_I,
  input wire logic ADAPTOR_SYSTEM_RESET_N_I,
  output logic PROCESSOR_SYSTEM_RESET_N_O,
  output logic PROCESSOR_DEBUG_RESET_N_O,
  input wire flash_path_pkg::bus_req_type BUS_REQ_I,
  output flash_path_pkg::bus_rsp_type BUS_RSP_O,
  output flash_path_pkg::region_type BUS_TARGET_O,
  output logic PATH_SELECT_O,
  input wire flash_path_pkg::flash_drive_type XIP_DRIVE_I,
  input wire flash_path_pkg::flash_drive_type NORMAL_DRIVE_I,
  output logic [3:0] XIP_DATA_O,
  output logic [3:0] NORMAL_DATA_O,
  output logic FLASH_SCLK_O,
  output logic FLASH_SELECT_N_O,
  input wire logic FLASH_IO0_I,
  output logic FLASH_IO0_O,
  output logic FLASH_IO0_OE_O,
  input wire logic FLASH_IO1_I,
  output logic FLASH_IO1_O,
  output logic FLASH_IO1_OE_O,
  input wire logic FLASH_IO2_I,
  output logic FLASH_IO2_O,
  output logic FLASH_IO2_OE_O,
  input wire logic FLASH_IO3_I,
  output logic FLASH_IO3_O,
  output logic FLASH_IO3_OE_O,
  input wire logic CFG_DETECT_I,
  input wire logic TERM_TX_I,
  output logic TERM_RX_O,
  output logic ADAPTOR_UART_TX_O,
  input wire logic ADAPTOR_UART_RX_I,
  output logic BASE_UART_TX_O,
  input wire logic BASE_UART_RX_I
);

  import flash_path_pkg::*;

  // RQ1 RQ2 RQ3 RQ9 address decode, first match wins
  function automatic region_type region_of(input logic [31:0] addr);
    region_type r;
    r = REGION_NONE;
    if (addr - XIP_MEM_BASE < XIP_MEM_SIZE) begin
      r = REGION_XIP_MEM;
    end else if (addr - XIP_CFG_BASE < PERIPH_SIZE) begin
      r = REGION_XIP_CFG;
    end else if (addr - PATH_SEL_BASE < PERIPH_SIZE) begin
      r = REGION_PATH_SEL;
    end else if (addr - NORMAL_BASE < PERIPH_SIZE) begin
      r = REGION_NORMAL;
    end else if (addr - SD_BASE < PERIPH_SIZE) begin
      r = REGION_SD;
    end
    return r;
  endfunction

  // ---------------- system clock domain ----------------

  logic adaptor_rstn_s;
  logic detect_s;
  logic applied_s;
  logic [1:0] uart_rx_s;
  logic sys_rstn_q;
  logic dbg_rstn_q;
  logic sel_q;
  logic sel_d;
  bus_rsp_type rsp_q;
  bus_rsp_type rsp_d;
  logic adaptor_tx_q;
  logic base_tx_q;
  logic term_rx_q;

  // pins entering the system domain
  level_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) rst_sync (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .data_i(ADAPTOR_SYSTEM_RESET_N_I),
    .data_o(adaptor_rstn_s)
  );

  level_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) detect_sync (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .data_i(CFG_DETECT_I),
    .data_o(detect_s)
  );

  level_sync #(.WIDTH(2), .RESET_VALUE(2'h3)) rx_sync (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .data_i({ADAPTOR_UART_RX_I, BASE_UART_RX_I}),
    .data_o(uart_rx_s)
  );

  // RQ13 system and debug resets
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sys_rstn_q <= 1'b0;
      dbg_rstn_q <= 1'b0;
    end else begin
      sys_rstn_q <= adaptor_rstn_s;
      dbg_rstn_q <= 1'b1;
    end
  end

  assign PROCESSOR_SYSTEM_RESET_N_O = sys_rstn_q;
  assign PROCESSOR_DEBUG_RESET_N_O = dbg_rstn_q;

  // bus decode and access classes
  wire region_type region = region_of(BUS_REQ_I.addr);
  wire req_valid = BUS_REQ_I.valid;
  wire sel_hit = req_valid && (region == REGION_PATH_SEL);
  wire sel_write = sel_hit && BUS_REQ_I.write;
  wire xip_hit = req_valid && (region == REGION_XIP_MEM);
  wire xip_refused = xip_hit && (BUS_REQ_I.write || sel_q);
  wire unmapped = req_valid && (region == REGION_NONE);
  wire [31:0] status_word = {29'h0, detect_s, applied_s, sel_q};

  // RQ1 route accesses to their controller
  assign BUS_TARGET_O = xip_refused ? REGION_NONE : region;

  // RQ4 select register write, RQ10 cleared by system reset
  assign sel_d = !sys_rstn_q ? SEL_RESET :
                 sel_write ? BUS_REQ_I.wdata[SEL_BIT] : sel_q;

  // RQ6 select register
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_q <= SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign PATH_SELECT_O = sel_q;

  // RQ5 answer for own register and refused accesses
  always_comb begin
    rsp_d = '0;
    rsp_d.ready = sel_hit || xip_refused || unmapped;
    rsp_d.error = xip_refused || unmapped;
    if (sel_hit && !BUS_REQ_I.write) begin
      rsp_d.rdata = status_word;
    end else begin
      rsp_d.rdata = READ_ZERO;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign BUS_RSP_O = rsp_q;

  // RQ11 terminal routing by jumper
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      adaptor_tx_q <= UART_IDLE;
      base_tx_q <= UART_IDLE;
      term_rx_q <= UART_IDLE;
    end else begin
      adaptor_tx_q <= detect_s ? TERM_TX_I : UART_IDLE;
      base_tx_q <= detect_s ? UART_IDLE : TERM_TX_I;
      term_rx_q <= detect_s ? uart_rx_s[1] : uart_rx_s[0];
    end
  end

  // RQ12 frames pass bit for bit, no retiming of baud
  assign ADAPTOR_UART_TX_O = adaptor_tx_q;
  assign BASE_UART_TX_O = base_tx_q;
  assign TERM_RX_O = term_rx_q;

  // ---------------- flash link clock domain ----------------

  logic sel_link_s;
  logic sel_link_q;
  logic [3:0] io_in_s;
  flash_drive_type pins_q;
  logic [3:0] xip_data_q;
  logic [3:0] normal_data_q;

  level_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) sel_to_link (
    .clk_i(LINK_CLK_I),
    .rstn_i(RSTN_I),
    .data_i(sel_q),
    .data_o(sel_link_s)
  );

  level_sync #(.WIDTH(4), .RESET_VALUE(4'h0)) io_sync (
    .clk_i(LINK_CLK_I),
    .rstn_i(RSTN_I),
    .data_i({FLASH_IO3_I, FLASH_IO2_I, FLASH_IO1_I, FLASH_IO0_I}),
    .data_o(io_in_s)
  );

  // applied select reported back to the system domain
  level_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) sel_to_sys (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .data_i(sel_link_q),
    .data_o(applied_s)
  );

  // RQ14 registered select in the link domain
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_link_q <= SEL_XIP;
    end else begin
      sel_link_q <= sel_link_s;
    end
  end

  // RQ7 pick the owner of all flash pins
  wire flash_drive_type pins_d =
    (sel_link_q == SEL_NORMAL) ? NORMAL_DRIVE_I : XIP_DRIVE_I;

  // RQ14 clock, select and lanes switch as one
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pins_q <= FLASH_IDLE;
    end else begin
      pins_q <= pins_d;
    end
  end

  // RQ5 read data goes only to the owner
  always_ff @(posedge LINK_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      xip_data_q <= 4'h0;
      normal_data_q <= 4'h0;
    end else begin
      xip_data_q <= sel_link_q ? 4'h0 : io_in_s;
      normal_data_q <= sel_link_q ? io_in_s : 4'h0;
    end
  end

  assign XIP_DATA_O = xip_data_q;
  assign NORMAL_DATA_O = normal_data_q;
  assign FLASH_SCLK_O = pins_q.sclk;
  assign FLASH_SELECT_N_O = pins_q.cs_n;
  assign FLASH_IO0_O = pins_q.io_out[0];
  assign FLASH_IO1_O = pins_q.io_out[1];
  assign FLASH_IO2_O = pins_q.io_out[2];
  assign FLASH_IO3_O = pins_q.io_out[3];
  assign FLASH_IO0_OE_O = pins_q.io_oe[0];
  assign FLASH_IO1_OE_O = pins_q.io_oe[1];
  assign FLASH_IO2_OE_O = pins_q.io_oe[2];
  assign FLASH_IO3_OE_O = pins_q.io_oe[3];

  // ---------------- checks ----------------

  // RQ1 memory window target
  a_xip_window_target: assert property ( // RQ1
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (req_valid && !BUS_REQ_I.write && !sel_q &&
     BUS_REQ_I.addr < XIP_MEM_SIZE) |-> BUS_TARGET_O == REGION_XIP_MEM)
    else $error("xip window read not routed to xip memory");

  // RQ2 configuration port target
  a_xip_cfg_target: assert property ( // RQ2
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (req_valid && BUS_REQ_I.addr == XIP_CFG_BASE)
    |-> BUS_TARGET_O == REGION_XIP_CFG)
    else $error("config port base not decoded");

  // RQ3 normal controller target
  a_normal_target: assert property ( // RQ3
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (req_valid && BUS_REQ_I.addr == NORMAL_BASE)
    |-> BUS_TARGET_O == REGION_NORMAL)
    else $error("normal controller base not decoded");

  // RQ4 written bit lands in the register
  a_select_write: assert property ( // RQ4
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (sel_write && sys_rstn_q) |=>
    PATH_SELECT_O == $past(BUS_REQ_I.wdata[0]) && BUS_RSP_O.ready)
    else $error("select write not stored");

  // RQ5 writes to the window are refused
  a_xip_write_refused: assert property ( // RQ5
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (xip_hit && BUS_REQ_I.write) |=>
    BUS_RSP_O.ready && BUS_RSP_O.error)
    else $error("write to xip window not refused");

  // RQ6 RQ10 system reset returns to the xip path
  a_reset_to_xip: assert property ( // RQ6
    @(posedge MCLK_I) disable iff (!RSTN_I)
    !sys_rstn_q |=> !PATH_SELECT_O)
    else $error("select not cleared by system reset");

  // RQ9 sd controller target
  a_sd_target: assert property ( // RQ9
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (req_valid && BUS_REQ_I.addr == SD_BASE)
    |-> BUS_TARGET_O == REGION_SD)
    else $error("sd controller base not decoded");

  // RQ11 terminal follows the jumper
  a_term_route: assert property ( // RQ11
    @(posedge MCLK_I) disable iff (!RSTN_I)
    detect_s |=> ADAPTOR_UART_TX_O == $past(TERM_TX_I) &&
    BASE_UART_TX_O == UART_IDLE)
    else $error("terminal not routed to adaptor port");

  // RQ13 adaptor reset leaves debug reset released
  a_debug_untouched: assert property ( // RQ13
    @(posedge MCLK_I) disable iff (!RSTN_I)
    (dbg_rstn_q && !adaptor_rstn_s) |=>
    !PROCESSOR_SYSTEM_RESET_N_O && PROCESSOR_DEBUG_RESET_N_O)
    else $error("adaptor reset touched the debug reset");

  // RQ5 RQ14 xip owner drives clock, select and IO3 enable
  a_pins_xip: assert property ( // RQ5
    @(posedge LINK_CLK_I) disable iff (!RSTN_I)
    !sel_link_q |=> FLASH_SCLK_O == $past(XIP_DRIVE_I.sclk) &&
    FLASH_SELECT_N_O == $past(XIP_DRIVE_I.cs_n) &&
    FLASH_IO3_OE_O == $past(XIP_DRIVE_I.io_oe[3]))
    else $error("pins not driven by xip controller");

  // RQ7 RQ14 normal owner drives clock, select and IO0 out
  a_pins_normal: assert property ( // RQ7
    @(posedge LINK_CLK_I) disable iff (!RSTN_I)
    sel_link_q |=> FLASH_SCLK_O == $past(NORMAL_DRIVE_I.sclk) &&
    FLASH_SELECT_N_O == $past(NORMAL_DRIVE_I.cs_n) &&
    FLASH_IO0_O == $past(NORMAL_DRIVE_I.io_out[0]))
    else $error("pins not driven by normal controller");

  // RQ14 applied select reaches the pins in bounded time
  a_select_applied: assert property ( // RQ14
    @(posedge MCLK_I) disable iff (!RSTN_I)
    $rose(sel_q) ##1 sel_q [*6] |-> applied_s)
    else $error("select change not applied to the link");

  c_switch_to_normal: cover property (
    @(posedge LINK_CLK_I) disable iff (!RSTN_I) $rose(sel_link_q));
  c_xip_refused: cover property (
    @(posedge MCLK_I) disable iff (!RSTN_I) xip_refused);
  c_adaptor_reset: cover property (
    @(posedge MCLK_I) disable iff (!RSTN_I) $fell(sys_rstn_q));
  c_status_read: cover property (
    @(posedge MCLK_I) disable iff (!RSTN_I)
    sel_hit && !BUS_REQ_I.write && detect_s);

endmodule // flash_path_mux

/* File: verification/flash_model.sv */
// behavioural quad flash that answers a read with a fixed nibble
`timescale 1ns/100ps
module flash_model #(
  parameter logic [3:0] READ_NIBBLE = 4'ha
) (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  output logic [3:0] data_o,
  output logic oe_o
);
  // output phase only while selected and clock high, else released
  assign oe_o = !cs_n_i && sclk_i;
  assign data_o = READ_NIBBLE;
endmodule // flash_model

/* File: verification/tb_top.sv */
// self-checking bench for the flash path select block
`timescale 1ns/100ps
module tb_top;
  import flash_path_pkg::*;
  logic mclk = 0;
  logic link_clk = 0;
  logic rstn = 0;
  logic adaptor_rst_n = 1;
  logic cfg_detect = 0;
  logic term_tx = 1;
  logic adaptor_rx = 1;
  logic base_rx = 1;
  logic junk = 0;
  bus_req_type req = '0;
  bus_rsp_type rsp_w;
  bus_rsp_type rsp;
  region_type tgt_w;
  region_type tgt;
  flash_drive_type xip_drv = '{1'b1, 1'b0, 4'h3, 4'h0};
  flash_drive_type normal_drv = '{1'b0, 1'b0, 4'hc, 4'hf};
  logic sys_rst_n, dbg_rst_n, path_sel, sclk, sel_n;
  logic term_rx, ad_tx, base_tx, model_oe;
  wire [3:0] xip_data, normal_data, pin_o, pin_oe, pin_i, model_data;
  logic [31:0] addr_tbl [5] = '{XIP_MEM_BASE + 32'h100, XIP_CFG_BASE,
    NORMAL_BASE + 32'h4, SD_BASE, 32'h5000_0000};
  region_type reg_tbl [5] = '{REGION_XIP_MEM, REGION_XIP_CFG,
    REGION_NORMAL, REGION_SD, REGION_NONE};
  int fails = 0;
  int compares = 0;

  // clocks and a level that changes every cycle for released lanes
  always #20 mclk = ~mclk;
  always #7.5 link_clk = ~link_clk;
  always @(posedge mclk) junk <= ~junk;

  // lane level: block first, then flash, else the changing value
  for (genvar n = 0; n < 4; n++) begin : g_lane
    assign pin_i[n] = pin_oe[n] ? pin_o[n] : (model_oe ? model_data[n] : junk);
  end

  flash_model flash (.sclk_i(sclk), .cs_n_i(sel_n), .data_o(model_data),
    .oe_o(model_oe));

  flash_path_mux dut (
    .MCLK_I(mclk), .RSTN_I(rstn), .LINK_CLK_I(link_clk),
    .ADAPTOR_SYSTEM_RESET_N_I(adaptor_rst_n),
    .PROCESSOR_SYSTEM_RESET_N_O(sys_rst_n),
    .PROCESSOR_DEBUG_RESET_N_O(dbg_rst_n),
    .BUS_REQ_I(req), .BUS_RSP_O(rsp_w), .BUS_TARGET_O(tgt_w),
    .PATH_SELECT_O(path_sel), .XIP_DRIVE_I(xip_drv),
    .NORMAL_DRIVE_I(normal_drv), .XIP_DATA_O(xip_data),
    .NORMAL_DATA_O(normal_data), .FLASH_SCLK_O(sclk),
    .FLASH_SELECT_N_O(sel_n),
    .FLASH_IO0_I(pin_i[0]), .FLASH_IO0_O(pin_o[0]), .FLASH_IO0_OE_O(pin_oe[0]),
    .FLASH_IO1_I(pin_i[1]), .FLASH_IO1_O(pin_o[1]), .FLASH_IO1_OE_O(pin_oe[1]),
    .FLASH_IO2_I(pin_i[2]), .FLASH_IO2_O(pin_o[2]), .FLASH_IO2_OE_O(pin_oe[2]),
    .FLASH_IO3_I(pin_i[3]), .FLASH_IO3_O(pin_o[3]), .FLASH_IO3_OE_O(pin_oe[3]),
    .CFG_DETECT_I(cfg_detect), .TERM_TX_I(term_tx), .TERM_RX_O(term_rx),
    .ADAPTOR_UART_TX_O(ad_tx), .ADAPTOR_UART_RX_I(adaptor_rx),
    .BASE_UART_TX_O(base_tx), .BASE_UART_RX_I(base_rx));

  // vector comparison
  task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bus target comparison
  task automatic chk_region(input region_type exp);
    compares++;
    if (tgt !== exp) begin
      fails++;
      $display("Error target expected %s seen %s", exp.name(), tgt.name());
    end
  endtask

  // settle a number of system cycles past the edge
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one-cycle request, target while valid, answer the cycle after
  task automatic bus(input logic wr, input logic [31:0] addr,
      input logic [31:0] wdata);
    @(posedge mclk);
    #1;
    req = '{1'b1, wr, addr, wdata};
    #1;
    tgt = tgt_w;
    @(posedge mclk);
    #1;
    req.valid = 1'b0;
    rsp = rsp_w;
  endtask

  // state straight after reset: read-only fetch path owns the pins
  task automatic t_reset;
    wait_cycles(8);
    chk("select", 0, path_sel);
    chk("debug reset", 1, dbg_rst_n);
    chk("system reset", 1, sys_rst_n);
    chk("pins", 32'h20, {sclk, sel_n, pin_oe});
    chk("pin out", 32'h3, pin_o);
    chk("data", 32'ha0, {xip_data, normal_data});
  endtask

  // decode of every region but the select register, and the unmapped hole
  task automatic t_decode;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, addr_tbl[i], 32'h0);
      chk_region(reg_tbl[i]);
      chk("answer", (i == 4) ? 3 : 0, {rsp.ready, rsp.error});
    end
    bus(1'b1, XIP_MEM_BASE, 32'h1);
    chk_region(REGION_NONE);
    chk("window write", 3, {rsp.ready, rsp.error});
  endtask

  // hand the pins to the normal controller and back off the window
  task automatic t_select;
    // bench code never runs from flash
    bus(1'b1, PATH_SEL_BASE, 32'h1);
    chk("write answer", 2, {rsp.ready, rsp.error});
    chk("select", 1, path_sel);
    wait_cycles(8);
    chk("pins", 32'h0f, {sclk, sel_n, pin_oe});
    chk("pin out", 32'hc, pin_o);
    chk("data", 32'h0c, {xip_data, normal_data});
    bus(1'b0, PATH_SEL_BASE, 32'h0);
    chk("status", 32'h3, rsp.rdata);
    bus(1'b0, XIP_MEM_BASE, 32'h0);
    chk_region(REGION_NONE);
    chk("window read", 3, {rsp.ready, rsp.error});
  endtask

  // adaptor reset clears select, keeps debug alive, then fetch returns
  task automatic t_adaptor_reset;
    adaptor_rst_n = 1'b0;
    wait_cycles(5);
    chk("system reset", 0, sys_rst_n);
    chk("debug reset", 1, dbg_rst_n);
    chk("select", 0, path_sel);
    bus(1'b1, PATH_SEL_BASE, 32'h1);
    wait_cycles(1);
    chk("select held", 0, path_sel);
    adaptor_rst_n = 1'b1;
    wait_cycles(8);
    chk("system reset", 1, sys_rst_n);
    chk("pins", 32'h20, {sclk, sel_n, pin_oe});
  endtask

  // terminal routing for both jumper settings, both directions
  task automatic t_terminal;
    for (int d = 0; d < 2; d++) begin
      cfg_detect = d[0];
      wait_cycles(4);
      bus(1'b0, PATH_SEL_BASE, 32'h0);
      chk("detect", {29'h0, d[0], 2'b00}, rsp.rdata);
      term_tx = 1'b0;
      wait_cycles(1);
      chk("tx ports", {30'h0, ~d[0], d[0]}, {ad_tx, base_tx});
      adaptor_rx = ~d[0];
      base_rx = d[0];
      wait_cycles(4);
      chk("rx", 0, term_rx);
      term_tx = 1'b1;
      adaptor_rx = 1'b1;
      base_rx = 1'b1;
    end
  endtask

  // counts, verdict and end of run
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_decode();
    t_select();
    t_adaptor_reset();
    t_terminal();
    results();
  end

  // watchdog well past the expected run length
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // tb_top
